// [ext_pulse_source.sv]
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Pulse source on the external count pin
// ----------------------------------------------------------------
module ext_pulse_source (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [8:0] pulses,
  input  wire logic       idleHigh,
  output logic            pin,
  output logic            busy
);
  logic [9:0] halvesLeft = 10'h000;
  logic       second     = 1'b0;

  // both levels held two clocks
  // Two clocks is the minimum, so the pin is as fast as the sampling allows
  always @(posedge clk) begin
    if (go) begin
      halvesLeft <= {pulses, 1'b0};
      second     <= 1'b0;
    end else if (halvesLeft != 10'h000) begin
      second <= ~second;
      if (second) begin
        halvesLeft <= halvesLeft - 10'h001;
      end
    end
  end

  assign pin  = idleHigh ^ halvesLeft[0];
  assign busy = halvesLeft != 10'h000;
endmodule : ext_pulse_source
`default_nettype wire

// [input_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module input_sync (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pinIn,
  input  wire logic invert,
  output logic      levelOut
);

  typedef struct packed {
    logic stage1;
    logic stage2;
  } sync_state_t;

  sync_state_t state_q;
  sync_state_t state_d;

  always_comb begin
    state_d        = state_q;
    state_d.stage1 = pinIn;
    state_d.stage2 = state_q.stage1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= '{stage1: 1'b0, stage2: 1'b0};
    end else begin
      state_q <= state_d;
    end
  end

  // Inversion turns a falling pin edge into a rising one
  assign levelOut = state_q.stage2 ^ invert;

  a_sync_latency: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) && !$past(sys_rst, 2) |-> state_q.stage2 == $past(pinIn, 2))
    else $error("pin not seen two cycles later");

endmodule : input_sync
`default_nettype wire

// [prescale_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface prescale_if;
  logic       pulse;
  logic       clear;
  logic [2:0] ratio;
  logic       outLevel;
  logic [7:0] count;

  modport ctrl   (output pulse, output clear, output ratio, input outLevel, input count);
  modport scaler (input pulse, input clear, input ratio, output outLevel, output count);
endinterface : prescale_if
`default_nettype wire

// [shared_prescaler.sv]
`timescale 1ns/1ns
`default_nettype none
module shared_prescaler
  import timer_counter_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  prescale_if.scaler pre
);

  typedef struct packed {
    logic [7:0] count;
  } scaler_state_t;

  scaler_state_t state_q;
  scaler_state_t state_d;

  always_comb begin
    state_d = state_q;
    if (pre.clear) begin
      state_d.count = PRESCALER_RESET;
    end else if (pre.pulse) begin
      state_d.count = state_q.count + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= '{count: PRESCALER_RESET};
    end else begin
      state_q <= state_d;
    end
  end

  // bit n toggles every 2^n pulses
  assign pre.outLevel = state_q.count[pre.ratio];
  assign pre.count    = state_q.count;

  a_step_count: assert property (@(posedge clk) disable iff (sys_rst)
    pre.pulse && !pre.clear |=> pre.count == $past(pre.count) + 8'h01)
    else $error("prescaler did not step");

  a_reset_clears: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(sys_rst) |-> pre.count == PRESCALER_RESET)
    else $error("prescaler not zero after reset");

  a_clear_wins: assert property (@(posedge clk) disable iff (sys_rst)
    pre.clear |=> pre.count == PRESCALER_RESET)
    else $error("prescaler clear lost");

endmodule : shared_prescaler
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
  import timer_counter_pkg::*;
  logic       clk          = 1'b0;
  logic       sys_rst      = 1'b1;
  logic [7:0] regAddr      = 8'h01;
  logic [7:0] regWriteData = 8'h00;
  logic [4:0] strobe       = 5'h00;
  logic       go           = 1'b0;
  logic       idleHigh     = 1'b1;
  logic [8:0] pulses       = 9'h000;
  logic       pin;
  logic       busy;
  logic       scaledTick;
  logic [7:0] readData;
  logic [7:0] optionConfig;
  logic [5:0] portCDirection;
  logic [7:0] firstRead;
  int         errTotal     = 0;
  int         totalChecks  = 0;
  int         cycles       = 0;
  int         seen         = 0;

  always #25 clk = ~clk;

  timer_counter_with_shared_prescaler timer_counter_with_shared_prescaler_inst (
    .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrite(strobe[0]),
    .regWriteData(regWriteData), .optionLoad(strobe[1]), .trisLoad(strobe[2]),
    .watchdogClear(strobe[3]), .watchdogTick(strobe[4]), .externalCountInput(pin),
    .readData(readData), .optionConfig(optionConfig), .portCDirection(portCDirection),
    .watchdogScaledTick(scaledTick)
  );

  ext_pulse_source ext_pulse_source_inst (
    .clk(clk), .go(go), .pulses(pulses), .idleHigh(idleHigh), .pin(pin), .busy(busy)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic tallyAndFinish();
    if (errTotal == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tallyAndFinish

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : check

  // One-cycle strobe: 0 count write, 1 option, 2 direction, 3 wd clear, 4 wd tick
  task automatic op(input int kind, input logic [7:0] d);
    @(posedge clk);
    regAddr      <= 8'h01;
    regWriteData <= d;
    strobe       <= 5'(5'h01 << kind);
    @(posedge clk);
    strobe <= 5'h00;
  endtask : op

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(readData, exp);
  endtask : rd

  // Waits out the sync latency, worst case seven clocks
  task automatic burst(input int n);
    @(posedge clk);
    pulses <= n[8:0];
    go     <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    while (busy === 1'b1) @(posedge clk);
    repeat (12) @(posedge clk);
  endtask : burst

  task automatic ticks(input int n);
    repeat (n) op(4, 8'h00);
    repeat (3) @(posedge clk);
  endtask : ticks

  // Counted on the falling edge, where the registered tick has settled
  always @(negedge clk) begin
    if (scaledTick === 1'b1) begin
      seen++;
    end
    cycles++;
    if (cycles == 20000) begin
      errTotal++;
      tallyAndFinish();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    check(optionConfig, OPTION_RESET);
    check({2'b00, portCDirection}, {2'b00, PORTC_DIR_RESET});
    ticks(127);
    check(seen[7:0], 8'h00);
    ticks(1);
    check(seen[7:0], 8'h01);
    op(2, 8'h15);
    @(negedge clk);
    check({2'b00, portCDirection}, 8'h15);
    op(1, 8'h39);
    op(3, 8'h00);
    seen = 0;
    ticks(1);
    op(3, 8'h00);
    ticks(1);
    check(seen[7:0], 8'h00);
    ticks(1);
    check(seen[7:0], 8'h01);
    op(3, 8'h00);
    op(1, 8'h30);
    op(0, 8'h40);
    seen = 0;
    ticks(3);
    check(seen[7:0], 8'h03);
    rd(8'h01, 8'h40);
    op(3, 8'h00);
    op(0, 8'h00);
    op(1, 8'h38);
    op(0, 8'hfd);
    repeat (10) @(posedge clk);
    burst(5);
    rd(8'h01, 8'h02);
    // Idle level changes only in timer mode, else it counts as an edge
    op(1, 8'h08);
    @(posedge clk);
    idleHigh <= 1'b0;
    op(1, 8'h28);
    op(0, 8'h80);
    repeat (10) @(posedge clk);
    burst(4);
    rd(8'h01, 8'h84);
    op(3, 8'h00);
    for (int n = 0; n < 8; n++) begin
      op(1, 8'h20 | n[7:0]);
      op(0, 8'h00);
      repeat (10) @(posedge clk);
      burst(3 << n);
      rd(8'h01, 8'h02);
    end
    op(3, 8'h00);
    op(0, 8'h00);
    op(1, 8'h08);
    op(0, 8'hfe);
    repeat (22) @(posedge clk);
    op(1, 8'h28);
    rd(8'h01, 8'h02);
    rd(8'h02, 8'h00);
    op(3, 8'h00);
    op(1, 8'h00);
    op(0, 8'h00);
    repeat (20) @(posedge clk);
    @(negedge clk);
    firstRead = readData;
    // 64 clocks are 16 instruction cycles, so eight steps at 1:2
    repeat (64) @(posedge clk);
    @(negedge clk);
    check(8'(readData - firstRead), 8'h08);
    tallyAndFinish();
  end
endmodule : tb
`default_nettype wire

// [timer_counter_pkg.sv]
`default_nettype none
package timer_counter_pkg;

  // ----------------------------------------------------------------
  // Register addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TIMER_COUNT_ADDR  = 8'h01;
  localparam logic [7:0] TIMER_COUNT_RESET = 8'h00;
  localparam logic [7:0] OPTION_RESET      = 8'hff;
  localparam logic [5:0] PORTC_DIR_RESET   = 6'h3f;
  localparam logic [7:0] PRESCALER_RESET   = 8'h00;

  // ----------------------------------------------------------------
  // Option register field positions and port C direction MSB
  // ----------------------------------------------------------------
  localparam int OPT_SOURCE_BIT = 5;
  localparam int OPT_EDGE_BIT   = 4;
  localparam int OPT_ASSIGN_BIT = 3;
  localparam int OPT_RATIO_MSB  = 2;
  localparam int OPT_RATIO_LSB  = 0;
  localparam int PORTC_DIR_MSB  = 5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'h2;

  // Four phase clocks per instruction cycle, Gray ordered
  typedef enum logic [1:0] {
    PHASE_Q1 = 2'h0,
    PHASE_Q2 = 2'h1,
    PHASE_Q3 = 2'h3,
    PHASE_Q4 = 2'h2
  } phase_t;

endpackage : timer_counter_pkg
`default_nettype wire

// [timer_counter_with_shared_prescaler.sv]
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Overview of operation
// - Source select zero: timer mode, one step per instruction cycle unscaled.
// - Any count write blocks increments for the next two instruction cycles.
// - Source select one: counter mode, steps on the chosen external edge.
// - Edge select zero counts rising edges, one counts falling edges.
// - Assignment bit zero gives prescaler to counter, one to watchdog.
// - Prescaled counter ratios run 1:2 to 1:256 in powers of two.
// - Prescaler is an 8-bit counter, watchdog postscaler when so assigned.
// - Prescaler contents are never readable or writable by software.
// - Count writes clear the prescaler while it serves the counter.
// - Watchdog clear clears the prescaler while it serves the watchdog.
// - Any reset loads the prescaler with zeros.
// - Prescaler output is sampled at the second and fourth phase clocks.
// - External count change follows the edge after synchronisation latency.
// - Count register is 8 bits, read and write at address 01h.
// ----------------------------------------------------------------
module timer_counter_with_shared_prescaler
  import timer_counter_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic [7:0] regWriteData,
  input  wire logic       optionLoad,
  input  wire logic       trisLoad,
  input  wire logic       watchdogClear,
  input  wire logic       watchdogTick,
  input  wire logic       externalCountInput,
  output logic      [7:0] readData,
  output logic      [7:0] optionConfig,
  output logic      [5:0] portCDirection,
  output logic            watchdogScaledTick
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    phase_t     phase;
    logic [7:0] count;
    logic [7:0] option;
    logic [5:0] portCDir;
    logic [1:0] inhibit;
    logic       selPrev;
    logic       sampled;
    logic       sampledPrev;
    logic       scaledPrev;
    logic       wdtTick;
    logic [7:0] readData;
  } core_state_t;

  // Count has no defined power-on value upstream; zero keeps simulation clean
  // Edge history starts high, so the reset edge select cannot fake a first edge
  localparam core_state_t CORE_RESET = '{
    phase:       PHASE_Q1,
    count:       TIMER_COUNT_RESET,
    option:      OPTION_RESET,
    portCDir:    PORTC_DIR_RESET,
    inhibit:     2'h0,
    selPrev:     1'b1,
    sampled:     1'b1,
    sampledPrev: 1'b1,
    scaledPrev:  1'b0,
    wdtTick:     1'b0,
    readData:    8'h00
  };

  core_state_t state_q;
  core_state_t state_d;

  logic instrTick;
  logic sampleSlot;
  logic countSource;
  logic edgeSelect;
  logic toWatchdog;
  logic countWrite;
  logic selLevel;
  logic srcLevel;
  logic sampledRise;
  logic incEvent;

  prescale_if preBus ();

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  assign instrTick   = (state_q.phase == PHASE_Q4);
  assign sampleSlot  = (state_q.phase == PHASE_Q2) || (state_q.phase == PHASE_Q4);
  assign countSource = state_q.option[OPT_SOURCE_BIT];
  assign edgeSelect  = state_q.option[OPT_EDGE_BIT];
  assign toWatchdog  = state_q.option[OPT_ASSIGN_BIT];

  always_comb begin
    if (regWrite && (regAddr == TIMER_COUNT_ADDR)) begin
      countWrite = 1'b1;
    end else begin
      countWrite = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // External input path
  // ----------------------------------------------------------------
  // edge choice by inversion
  // Toggling edge select while the pin is steady can look like one edge
  input_sync u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pinIn    (externalCountInput),
    .invert   (edgeSelect),
    .levelOut (selLevel)
  );

  // ----------------------------------------------------------------
  // Prescaler hookup
  // ----------------------------------------------------------------
  // one user at a time
  assign preBus.pulse = toWatchdog ? watchdogTick :
                        (countSource ? (selLevel & ~state_q.selPrev) : instrTick);

  assign preBus.ratio = state_q.option[OPT_RATIO_MSB:OPT_RATIO_LSB];

  assign preBus.clear = (countWrite && !toWatchdog) || (watchdogClear && toWatchdog);

  shared_prescaler u_prescaler (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pre     (preBus)
  );

  assign srcLevel    = toWatchdog ? selLevel : preBus.outLevel;
  assign sampledRise = state_q.sampled & ~state_q.sampledPrev;

  // counter mode steps on sampled edge
  assign incEvent = (state_q.inhibit == 2'h0) && !countWrite &&
                    ((!countSource && toWatchdog) ? instrTick : sampledRise);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;

    case (state_q.phase)
      PHASE_Q1: begin
        state_d.phase = PHASE_Q2;
      end
      PHASE_Q2: begin
        state_d.phase = PHASE_Q3;
      end
      PHASE_Q3: begin
        state_d.phase = PHASE_Q4;
      end
      PHASE_Q4: begin
        state_d.phase = PHASE_Q1;
      end
      default: begin
        state_d.phase = PHASE_Q1;
      end
    endcase

    state_d.selPrev     = selLevel;
    state_d.sampledPrev = state_q.sampled;
    state_d.scaledPrev  = preBus.outLevel;

    if (sampleSlot) begin
      state_d.sampled = srcLevel;
    end

    if (instrTick && (state_q.inhibit != 2'h0)) begin
      state_d.inhibit = state_q.inhibit - 2'h1;
    end

    if (incEvent) begin
      state_d.count = state_q.count + 8'h01;
    end

    if (countWrite) begin
      state_d.count   = regWriteData;
      state_d.inhibit = WRITE_INHIBIT_CYCLES;
    end

    if (optionLoad) begin
      state_d.option = regWriteData;
    end

    if (trisLoad) begin
      state_d.portCDir = regWriteData[PORTC_DIR_MSB:0];
    end

    if (toWatchdog) begin
      state_d.wdtTick = preBus.outLevel & ~state_q.scaledPrev;
    end else begin
      state_d.wdtTick = watchdogTick;
    end

    if (regAddr == TIMER_COUNT_ADDR) begin
      state_d.readData = state_q.count;
    end else begin
      state_d.readData = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= CORE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign readData           = state_q.readData;
  assign optionConfig       = state_q.option;
  assign portCDirection     = state_q.portCDir;
  assign watchdogScaledTick = state_q.wdtTick;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_timer_tick: assert property (
    !countSource && toWatchdog && (state_q.inhibit == 2'h0) && instrTick && !countWrite
    |=> state_q.count == $past(state_q.count) + 8'h01)
    else $error("timer mode missed a cycle step");

  a_inhibit_load: assert property (
    countWrite |=> state_q.inhibit == WRITE_INHIBIT_CYCLES)
    else $error("write did not open inhibit window");

  a_inhibit_hold: assert property (
    (state_q.inhibit != 2'h0) && !countWrite |=> $stable(state_q.count))
    else $error("count moved inside inhibit window");

  a_counter_quiet: assert property (
    countSource && !countWrite && !sampledRise |=> $stable(state_q.count))
    else $error("counter mode stepped without edge");

  a_counter_step: assert property (
    countSource && sampledRise && (state_q.inhibit == 2'h0) && !countWrite
    |=> state_q.count == $past(state_q.count) + 8'h01)
    else $error("synchronised edge did not step the count");

  a_scaled_quiet: assert property (
    !countSource && !toWatchdog && !countWrite && !sampledRise |=> $stable(state_q.count))
    else $error("scaled timer stepped without a tap edge");

  a_postscale_tick: assert property (
    toWatchdog && preBus.outLevel && !state_q.scaledPrev |=> watchdogScaledTick)
    else $error("postscaler edge did not reach the watchdog");

  a_wdt_pass: assert property (
    !toWatchdog |=> watchdogScaledTick == $past(watchdogTick))
    else $error("watchdog tick scaled while prescaler serves counter");

  a_write_clear: assert property (
    countWrite && !toWatchdog |=> preBus.count == PRESCALER_RESET)
    else $error("count write left prescaler uncleared");

  a_wdt_clear: assert property (
    watchdogClear && toWatchdog |=> preBus.count == PRESCALER_RESET)
    else $error("watchdog clear left prescaler uncleared");

  a_sample_phase: assert property (
    $changed(state_q.sampled) |-> ($past(state_q.phase) == PHASE_Q2) || ($past(state_q.phase) == PHASE_Q4))
    else $error("sample taken outside Q2 or Q4");

  a_count_write: assert property (
    countWrite |=> state_q.count == $past(regWriteData))
    else $error("count write not stored");

  a_read_back: assert property (
    regAddr == TIMER_COUNT_ADDR |=> readData == $past(state_q.count))
    else $error("readback does not show count");

endmodule : timer_counter_with_shared_prescaler
`default_nettype wire
